// [rtl/asp_serial_port.sv]
// Summary of operation
// - Power enable low stops every serial circuit and saves power.
// - Bit rates up to 312.5 kbps are supported.
// - One serial output pin transmits, one serial input pin receives.
// - Character length selects seven or eight data bits.
// - A 5-bit counter divides the base clock into the bit clock.
// - Transmitter and receiver run independently at the same time.
// - Data bits move least significant bit first.
// - With port clock stopped, state freezes and output keeps its level.
// - Enables sync to base clock; wait two base clocks before re-enabling.
// - Each completed byte moves from receive shifter to receive buffer unless the buffer is full.
// - Seven-bit mode fills buffer bits 0 to 6, bit 7 reads zero.
// - On overrun the new byte is dropped, buffer keeps old data.
// - Receive buffer is read as a byte; writes to it do nothing.
// - Receive buffer becomes all ones on reset or power enable clear.
// - Receive shifter deserialises input and is hidden from software.
// - Writing transmit shift register starts sending; reads return no data.
// - Transmit shifter all ones on reset, power clear or transmit clear.
// - Parity select: none, fixed zero unchecked, odd, or even.
// - Transmitter sends one or two stops; receiver checks the first.
// - Error flags set at reception end, clear on status read or with both power and receive enable low.
// - Bit clock is base clock over k from 8 to 31.
module asp_serial_port (
	// Clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	// Port clock supply and timer base clock source
	input  wire logic        i_clk_supply,
	input  wire logic        i_timer_tick,
	// Internal data bus
	input  wire logic [15:0] i_addr,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic [7:0]  i_wdata,
	output logic      [7:0]  o_rdata,
	// Serial pins
	input  wire logic        i_serial_in_pin,
	output logic             o_serial_out_pin,
	// Events and flow
	output logic             o_transmit_done_irq,
	output logic             o_tx_ready
);

	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_START  = 5'h02,
		ST_DATA   = 5'h04,
		ST_PARITY = 5'h08,
		ST_STOP   = 5'h10
	} asp_state_e;

	////////////////////////////////////////////////////////////////////////////
	// Decode helpers
	function automatic logic [2:0] last_bit(input logic char8);
		last_bit = char8 ? asp_pkg::LAST_BIT_8 : asp_pkg::LAST_BIT_7;
	endfunction

	function automatic logic [7:0] char_mask(input logic char8, input logic [7:0] d);
		char_mask = char8 ? d : {1'b0, d[6:0]};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [7:0]  serial_mode_reg_r;
	logic [7:0]  baud_control_reg_r;
	logic [2:0]  receive_error_status_reg_r;
	logic [7:0]  receive_buffer_reg_r;
	logic        rxb_full_r;
	logic [4:0]  pre_cnt_r;
	logic        base_bit_clock;
	logic        txe_s1_r;
	logic        txe_s2_r;
	logic        rxe_s1_r;
	logic        rxe_s2_r;
	asp_state_e  tx_state_r;
	logic [4:0]  tx_cnt_r;
	logic [2:0]  tx_bit_r;
	logic [7:0]  transmit_shift_reg_r;
	logic        tx_par_r;
	logic        tx_stop2_r;
	logic        tx_out_r;
	logic        tx_done_r;
	asp_state_e  rx_state_r;
	logic [4:0]  rx_cnt_r;
	logic [2:0]  rx_bit_r;
	logic [7:0]  receive_shift_reg_r;
	logic        rx_perr_r;
	logic        rx_done;
	logic        rx_ferr;
	logic [7:0]  rx_data;
	logic        rx_in;
	logic        port_power_enable;
	logic        transmit_enable_bit;
	logic        receive_enable_bit;
	logic [1:0]  par_sel;
	logic        char_length_select;
	logic        stop_length_select;
	logic [4:0]  div_k;
	logic [4:0]  div_last;
	logic        tx_bit_end;
	logic        rx_bit_end;
	logic        wr_mode;
	logic        wr_baud;
	logic        wr_data;
	logic        rd_status;
	logic        rd_buffer;
	logic        fifo_valid;
	logic        fifo_pop;
	logic [7:0]  fifo_data;
	logic        tx_rst;
	logic        rx_rst;
	logic [7:0]  tx_load;

	assign port_power_enable   = serial_mode_reg_r[asp_pkg::BIT_POWER];
	assign transmit_enable_bit = serial_mode_reg_r[asp_pkg::BIT_TX_ENABLE];
	assign receive_enable_bit  = serial_mode_reg_r[asp_pkg::BIT_RX_ENABLE];
	assign par_sel             = serial_mode_reg_r[asp_pkg::BIT_PARITY_HI:asp_pkg::BIT_PARITY_LO];
	assign char_length_select  = serial_mode_reg_r[asp_pkg::BIT_CHAR_LEN];
	assign stop_length_select  = serial_mode_reg_r[asp_pkg::BIT_STOP_LEN];
	assign div_k               = baud_control_reg_r[asp_pkg::DIV_MSB:asp_pkg::DIV_LSB];
	assign div_last            = div_k - 5'h01;
	assign rx_in               = port_power_enable ? i_serial_in_pin : 1'b1;

	////////////////////////////////////////////////////////////////////////////
	// Bus decode
	always_comb begin
		wr_mode   = 1'b0;
		wr_baud   = 1'b0;
		wr_data   = 1'b0;
		rd_status = 1'b0;
		rd_buffer = 1'b0;
		if (i_addr == asp_pkg::ADDR_SERIAL_MODE) begin
			wr_mode = i_wr;
		end else if (i_addr == asp_pkg::ADDR_BAUD_CONTROL) begin
			wr_baud = i_wr;
		end else if (i_addr == asp_pkg::ADDR_DATA) begin
			wr_data   = i_wr;
			rd_buffer = i_rd;
		end else if (i_addr == asp_pkg::ADDR_RX_ERR_STATUS) begin
			rd_status = i_rd;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control registers
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			serial_mode_reg_r  <= asp_pkg::RST_SERIAL_MODE;
			baud_control_reg_r <= asp_pkg::RST_BAUD_CONTROL;
		end else begin
			if (wr_mode) begin
				serial_mode_reg_r <= {i_wdata[7:1], 1'b1};
			end
			if (wr_baud) begin
				baud_control_reg_r <= {i_wdata[7:6], 1'b0, i_wdata[4:0]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_rdata <= asp_pkg::READ_NONE;
		end else if (i_rd) begin
			if (i_addr == asp_pkg::ADDR_SERIAL_MODE) begin
				o_rdata <= serial_mode_reg_r;
			end else if (i_addr == asp_pkg::ADDR_BAUD_CONTROL) begin
				o_rdata <= baud_control_reg_r;
			end else if (i_addr == asp_pkg::ADDR_DATA) begin
				o_rdata <= receive_buffer_reg_r;
			end else if (i_addr == asp_pkg::ADDR_RX_ERR_STATUS) begin
				o_rdata <= {5'h00, receive_error_status_reg_r};
			end else begin
				o_rdata <= asp_pkg::READ_NONE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Base clock prescaler
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || !port_power_enable) begin
			pre_cnt_r <= 5'h00;
		end else if (i_clk_supply) begin
			pre_cnt_r <= pre_cnt_r + 5'h01;
		end
	end

	always_comb begin
		case (baud_control_reg_r[asp_pkg::TPS_MSB:asp_pkg::TPS_LSB])
			asp_pkg::TPS_DIV2:  base_bit_clock = pre_cnt_r[0];
			asp_pkg::TPS_DIV8:  base_bit_clock = &pre_cnt_r[2:0];
			asp_pkg::TPS_DIV32: base_bit_clock = &pre_cnt_r;
			default:            base_bit_clock = i_timer_tick;
		endcase
		base_bit_clock = base_bit_clock && i_clk_supply && port_power_enable;
	end

	////////////////////////////////////////////////////////////////////////////
	// Enable synchronisers on the base clock
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || !port_power_enable) begin
			txe_s1_r <= 1'b0;
			txe_s2_r <= 1'b0;
			rxe_s1_r <= 1'b0;
			rxe_s2_r <= 1'b0;
		end else if (base_bit_clock) begin
			txe_s1_r <= transmit_enable_bit;
			txe_s2_r <= txe_s1_r;
			rxe_s1_r <= receive_enable_bit;
			rxe_s2_r <= rxe_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmit path: writes queue in the FIFO, engine drains it
	assign tx_rst   = i_sys_rst || !port_power_enable || !transmit_enable_bit;
	assign fifo_pop = base_bit_clock && txe_s2_r && (tx_state_r == ST_IDLE);
	assign tx_load  = char_mask(char_length_select, fifo_data);

	asp_fifo #(
		.WIDTH (asp_pkg::DATA_W),
		.DEPTH (asp_pkg::TX_FIFO_DEPTH)
	) u_tx_fifo (
		.i_ref_clk   (i_ref_clk),
		.i_sys_rst   (i_sys_rst),
		.i_flush     (tx_rst),
		.i_in_valid  (wr_data),
		.o_in_ready  (o_tx_ready),
		.i_in_data   (i_wdata),
		.o_out_valid (fifo_valid),
		.i_out_ready (fifo_pop),
		.o_out_data  (fifo_data)
	);

	assign tx_bit_end = (tx_cnt_r == div_last);

	always_ff @(posedge i_ref_clk) begin
		if (tx_rst || !txe_s2_r) begin
			tx_state_r           <= ST_IDLE;
			tx_cnt_r             <= 5'h00;
			tx_bit_r             <= 3'h0;
			transmit_shift_reg_r <= asp_pkg::RST_TX_SHIFT;
			tx_par_r             <= 1'b0;
			tx_stop2_r           <= 1'b0;
			tx_out_r             <= 1'b1;
			tx_done_r            <= 1'b0;
		end else begin
			tx_done_r <= 1'b0;
			if (base_bit_clock) begin
				tx_cnt_r <= tx_bit_end ? 5'h00 : tx_cnt_r + 5'h01;
				case (tx_state_r)
					ST_IDLE: begin
						tx_cnt_r <= 5'h00;
						tx_out_r <= 1'b1;
						if (fifo_valid) begin
							transmit_shift_reg_r <= tx_load;
							case (par_sel)
								asp_pkg::PAR_ODD:  tx_par_r <= ~^tx_load;
								asp_pkg::PAR_EVEN: tx_par_r <= ^tx_load;
								default:           tx_par_r <= 1'b0;
							endcase
							tx_out_r   <= 1'b0;
							tx_stop2_r <= 1'b0;
							tx_state_r <= ST_START;
						end
					end
					ST_START: begin
						if (tx_bit_end) begin
							tx_out_r   <= transmit_shift_reg_r[0];
							tx_bit_r   <= 3'h0;
							tx_state_r <= ST_DATA;
						end
					end
					ST_DATA: begin
						if (tx_bit_end) begin
							transmit_shift_reg_r <= {1'b1, transmit_shift_reg_r[7:1]};
							tx_bit_r             <= tx_bit_r + 3'h1;
							if (tx_bit_r == last_bit(char_length_select)) begin
								if (par_sel != asp_pkg::PAR_NONE) begin
									tx_out_r   <= tx_par_r;
									tx_state_r <= ST_PARITY;
								end else begin
									tx_out_r   <= 1'b1;
									tx_state_r <= ST_STOP;
								end
							end else begin
								tx_out_r <= transmit_shift_reg_r[1];
							end
						end
					end
					ST_PARITY: begin
						if (tx_bit_end) begin
							tx_out_r   <= 1'b1;
							tx_state_r <= ST_STOP;
						end
					end
					ST_STOP: begin
						if (tx_bit_end) begin
							if (stop_length_select && !tx_stop2_r) begin
								tx_stop2_r <= 1'b1;
							end else begin
								tx_done_r  <= 1'b1;
								tx_state_r <= ST_IDLE;
							end
						end
					end
					default: tx_state_r <= ST_IDLE;
				endcase
			end
		end
	end

	assign o_serial_out_pin    = tx_out_r;
	assign o_transmit_done_irq = tx_done_r;

	////////////////////////////////////////////////////////////////////////////
	// Receive path
	assign rx_rst     = i_sys_rst || !port_power_enable || !receive_enable_bit || !rxe_s2_r;
	assign rx_bit_end = (rx_cnt_r == div_last);
	assign rx_data    = char_length_select ? receive_shift_reg_r
	                                       : {1'b0, receive_shift_reg_r[7:1]};
	assign rx_done    = base_bit_clock && (rx_state_r == ST_STOP) && rx_bit_end;
	assign rx_ferr    = !rx_in;

	always_ff @(posedge i_ref_clk) begin
		if (rx_rst) begin
			rx_state_r          <= ST_IDLE;
			rx_cnt_r            <= 5'h00;
			rx_bit_r            <= 3'h0;
			receive_shift_reg_r <= 8'hFF;
			rx_perr_r           <= 1'b0;
		end else if (base_bit_clock) begin
			rx_cnt_r <= rx_bit_end ? 5'h00 : rx_cnt_r + 5'h01;
			case (rx_state_r)
				ST_IDLE: begin
					rx_cnt_r <= 5'h00;
					if (!rx_in) begin
						rx_perr_r  <= 1'b0;
						rx_state_r <= ST_START;
					end
				end
				ST_START: begin
					if (rx_cnt_r == {1'b0, div_k[4:1]}) begin
						rx_cnt_r   <= 5'h00;
						rx_bit_r   <= 3'h0;
						rx_state_r <= rx_in ? ST_IDLE : ST_DATA;
					end
				end
				ST_DATA: begin
					if (rx_bit_end) begin
						receive_shift_reg_r <= {rx_in, receive_shift_reg_r[7:1]};
						rx_bit_r            <= rx_bit_r + 3'h1;
						if (rx_bit_r == last_bit(char_length_select)) begin
							rx_state_r <= (par_sel != asp_pkg::PAR_NONE) ? ST_PARITY : ST_STOP;
						end
					end
				end
				ST_PARITY: begin
					if (rx_bit_end) begin
						if (par_sel == asp_pkg::PAR_ODD) begin
							rx_perr_r <= ~(^{rx_data, rx_in});
						end else if (par_sel == asp_pkg::PAR_EVEN) begin
							rx_perr_r <= ^{rx_data, rx_in};
						end
						rx_state_r <= ST_STOP;
					end
				end
				ST_STOP: begin
					if (rx_bit_end) begin
						rx_state_r <= ST_IDLE;
					end
				end
				default: rx_state_r <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive buffer
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || !port_power_enable) begin
			receive_buffer_reg_r <= asp_pkg::RST_RX_BUFFER;
			rxb_full_r           <= 1'b0;
		end else if (rx_done && !rxb_full_r) begin
			receive_buffer_reg_r <= rx_data;
			rxb_full_r           <= 1'b1;
		end else if (rd_buffer) begin
			rxb_full_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive error status
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || (!port_power_enable && !receive_enable_bit)) begin
			receive_error_status_reg_r <= asp_pkg::RST_RX_ERR_STATUS[2:0];
		end else if (rx_done) begin
			receive_error_status_reg_r[asp_pkg::BIT_PARITY_ERR] <= rx_perr_r
				|| (receive_error_status_reg_r[asp_pkg::BIT_PARITY_ERR] && !rd_status);
			receive_error_status_reg_r[asp_pkg::BIT_FRAMING_ERR] <= rx_ferr
				|| (receive_error_status_reg_r[asp_pkg::BIT_FRAMING_ERR] && !rd_status);
			receive_error_status_reg_r[asp_pkg::BIT_OVERRUN] <= rxb_full_r
				|| (receive_error_status_reg_r[asp_pkg::BIT_OVERRUN] && !rd_status);
		end else if (rd_status) begin
			receive_error_status_reg_r <= asp_pkg::RST_RX_ERR_STATUS[2:0];
		end
	end

endmodule

// [rtl/asp_pkg.sv]
package asp_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register addresses on the internal data bus
	localparam logic [15:0] ADDR_SERIAL_MODE    = 16'hFF70;
	localparam logic [15:0] ADDR_BAUD_CONTROL   = 16'hFF71;
	localparam logic [15:0] ADDR_DATA           = 16'hFF72;
	localparam logic [15:0] ADDR_RX_ERR_STATUS  = 16'hFF73;

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0]  RST_SERIAL_MODE     = 8'h01;
	localparam logic [7:0]  RST_BAUD_CONTROL    = 8'h1F;
	localparam logic [7:0]  RST_RX_ERR_STATUS   = 8'h00;
	localparam logic [7:0]  RST_RX_BUFFER       = 8'hFF;
	localparam logic [7:0]  RST_TX_SHIFT        = 8'hFF;
	localparam logic [7:0]  READ_NONE           = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Serial mode register fields
	localparam int          BIT_POWER           = 7;
	localparam int          BIT_TX_ENABLE       = 6;
	localparam int          BIT_RX_ENABLE       = 5;
	localparam int          BIT_PARITY_HI       = 4;
	localparam int          BIT_PARITY_LO       = 3;
	localparam int          BIT_CHAR_LEN        = 2;
	localparam int          BIT_STOP_LEN        = 1;
	localparam int          BIT_MODE_FIXED_ONE  = 0;

	// Parity select codes
	localparam logic [1:0]  PAR_NONE            = 2'h0;
	localparam logic [1:0]  PAR_ZERO            = 2'h1;
	localparam logic [1:0]  PAR_ODD             = 2'h2;
	localparam logic [1:0]  PAR_EVEN            = 2'h3;

	////////////////////////////////////////////////////////////////////////////
	// Receive error status fields
	localparam int          BIT_PARITY_ERR      = 2;
	localparam int          BIT_FRAMING_ERR     = 1;
	localparam int          BIT_OVERRUN         = 0;

	////////////////////////////////////////////////////////////////////////////
	// Baud control fields and base clock select codes
	localparam int          TPS_MSB             = 7;
	localparam int          TPS_LSB             = 6;
	localparam int          DIV_MSB             = 4;
	localparam int          DIV_LSB             = 0;
	localparam logic [1:0]  TPS_TIMER           = 2'h0;
	localparam logic [1:0]  TPS_DIV2            = 2'h1;
	localparam logic [1:0]  TPS_DIV8            = 2'h2;
	localparam logic [1:0]  TPS_DIV32           = 2'h3;
	localparam logic [4:0]  DIV_MIN             = 5'h08;

	////////////////////////////////////////////////////////////////////////////
	// Rates and sizes
	localparam int          MAX_RATE_BPS_X10    = 3125000;
	localparam int          DATA_W              = 8;
	localparam int          TX_FIFO_DEPTH       = 8;
	localparam logic [2:0]  LAST_BIT_8          = 3'h7;
	localparam logic [2:0]  LAST_BIT_7          = 3'h6;

endpackage

// [rtl/asp_fifo.sv]
module asp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             i_ref_clk,
	input  wire logic             i_sys_rst,
	input  wire logic             i_flush,
	// Fill side
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	// Drain side
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	logic             push;
	logic             pop;

	assign o_in_ready  = (count_r != DEPTH[AW:0]);
	assign o_out_valid = (count_r != '0);
	assign o_out_data  = mem_r[rd_ptr_r];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	////////////////////////////////////////////////////////////////////////////
	// Storage
	always_ff @(posedge i_ref_clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= i_in_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pointers and fill level
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || i_flush) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end

endmodule

// [tb/asp_serial_port_asserts.sv]
module asp_chk (
	// Clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	// Bus
	input  wire logic [15:0] i_addr,
	input  wire logic        i_rd,
	input  wire logic [7:0]  o_rdata,
	// Serial side
	input  wire logic        o_serial_out_pin,
	input  wire logic        o_transmit_done_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	logic unmapped;
	assign unmapped = (i_addr < 16'hFF70) || (i_addr > 16'hFF73);
	////////////////////////////////////////////////////////////////////////////
	chk_reset_idle: assert property (disable iff (1'b0)
		i_sys_rst |=> o_serial_out_pin && o_rdata == 8'h00) else $error("reset state wrong");
	chk_irq_pulse: assert property (
		o_transmit_done_irq |=> !o_transmit_done_irq) else $error("done pulse too long");
	chk_irq_after_stop: assert property (
		o_transmit_done_irq |-> o_serial_out_pin && $past(o_serial_out_pin))
		else $error("done pulse not after stop bit");
	chk_start_width: assert property (
		$fell(o_serial_out_pin) |-> !o_serial_out_pin [*8]) else $error("start bit short");
	chk_unmapped_zero: assert property (
		i_rd && unmapped |=> o_rdata == 8'h00) else $error("unmapped read not zero");
	chk_mode_fixed_one: assert property (
		i_rd && i_addr == asp_pkg::ADDR_SERIAL_MODE |=> o_rdata[0])
		else $error("mode bit 0 not one");
	chk_status_high_zero: assert property (
		i_rd && i_addr == asp_pkg::ADDR_RX_ERR_STATUS |=> o_rdata[7:3] == 5'h00)
		else $error("status upper bits set");
	chk_baud_gap_zero: assert property (
		i_rd && i_addr == asp_pkg::ADDR_BAUD_CONTROL |=> !o_rdata[5])
		else $error("baud bit 5 set");
	chk_rdata_hold: assert property (
		!i_rd |=> $stable(o_rdata)) else $error("read data moved without read");
	cover property (o_transmit_done_irq);
	cover property ($fell(o_serial_out_pin));
	cover property (i_rd && i_addr == asp_pkg::ADDR_RX_ERR_STATUS ##1 o_rdata != 8'h00);
endmodule

bind asp_serial_port asp_chk u_asp_chk (
	.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_rd(i_rd),
	.o_rdata(o_rdata), .o_serial_out_pin(o_serial_out_pin),
	.o_transmit_done_irq(o_transmit_done_irq)
);

// [tb/asp_remote_uart.sv]
module asp_remote_uart #(
	parameter int BIT_NS = 80
) (
	// Serial lines seen from the far end
	input  wire logic i_line_in,
	output logic      o_line_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial o_line_out = 1'b1;
	////////////////////////////////////////////////////////////////////////////
	// Start bit, then n frame bits first to last, then marking level
	task automatic send(input logic [11:0] bits, input int n);
		o_line_out = 1'b0;
		#(BIT_NS);
		for (int i = 0; i < n; i++) begin
			o_line_out = bits[i];
			#(BIT_NS);
		end
		o_line_out = 1'b1;
	endtask
	// Samples n frame bits at mid bit after a falling start edge
	task automatic recv(input int n, output logic [11:0] bits);
		bits = 12'h000;
		@(negedge i_line_in);
		#(BIT_NS / 2);
		for (int i = 0; i < n; i++) begin
			#(BIT_NS);
			bits[i] = i_line_in;
		end
	endtask
endmodule

// [tb/test_async_serial_port_core.sv]
module test_async_serial_port_core;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_ref_clk = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic [15:0] i_addr    = 16'h0000;
	logic        i_wr      = 1'b0;
	logic        i_rd      = 1'b0;
	logic [7:0]  i_wdata   = 8'h00;
	logic [7:0]  o_rdata;
	logic        rx_line;
	logic        o_serial_out_pin;
	logic        o_transmit_done_irq;
	logic        o_tx_ready;
	logic [11:0] got;
	logic        clk_supply = 1'b1;
	logic        timer_tick = 1'b0;
	int          errors    = 0;
	int          cmp_count = 0;
	always #2.5 i_ref_clk = ~i_ref_clk;
	// External base clock source, one pulse every second cycle
	always @(negedge i_ref_clk) timer_tick <= ~timer_tick;
	asp_serial_port u_asp_serial_port (
		.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
		.i_clk_supply(clk_supply), .i_timer_tick(timer_tick),
		.i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
		.i_serial_in_pin(rx_line), .o_serial_out_pin(o_serial_out_pin),
		.o_transmit_done_irq(o_transmit_done_irq), .o_tx_ready(o_tx_ready)
	);
	asp_remote_uart #(.BIT_NS(80)) u_asp_remote_uart (
		.i_line_in(o_serial_out_pin), .o_line_out(rx_line)
	);
	////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge i_ref_clk);
		i_addr = a;
		i_wdata = d;
		i_wr = 1'b1;
		@(negedge i_ref_clk);
		i_wr = 1'b0;
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
		@(negedge i_ref_clk);
		i_addr = a;
		i_rd = 1'b1;
		@(negedge i_ref_clk);
		i_rd = 1'b0;
		check($sformatf("rdata_%h", a), {4'h0, o_rdata}, {4'h0, exp});
	endtask
	// Power on with both directions off, settle, then the new mode
	task automatic mode(input logic [7:0] m);
		wr(16'hFF70, 8'h81);
		repeat (10) @(negedge i_ref_clk);
		wr(16'hFF70, m);
		repeat (10) @(negedge i_ref_clk);
	endtask
	task automatic tx_chk(input logic [7:0] d, input logic [11:0] exp, input int n);
		int k = 0;
		fork
			u_asp_remote_uart.recv(n, got);
			wr(16'hFF72, d);
		join
		check("serial_frame", got, exp);
		while (o_transmit_done_irq !== 1'b1 && k < 100) begin
			@(negedge i_ref_clk);
			k++;
		end
		check("done_irq", {11'h000, o_transmit_done_irq}, 12'h001);
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		errors++;
		$display("watchdog expired");
		close_out();
	end
	initial begin
		repeat (5) @(posedge i_ref_clk);
		@(negedge i_ref_clk);
		i_sys_rst = 1'b0;
		rd_chk(16'hFF70, 8'h01);
		rd_chk(16'hFF71, 8'h1F);
		rd_chk(16'hFF73, 8'h00);
		rd_chk(16'hFF72, 8'hFF);
		rd_chk(16'hFF74, 8'h00);
		wr(16'hFF73, 8'h07);
		rd_chk(16'hFF73, 8'h00);
		wr(16'hFF71, 8'h48);
		rd_chk(16'hFF71, 8'h48);
		$display("test registers done");
		mode(8'hE7);
		fork
			u_asp_remote_uart.send(12'h1A5, 9);
			tx_chk(8'h3C, 12'h33C, 10);
		join
		rd_chk(16'hFF72, 8'hA5);
		$display("test full duplex done");
		u_asp_remote_uart.send(12'h111, 9);
		u_asp_remote_uart.send(12'h122, 9);
		rd_chk(16'hFF73, 8'h01);
		rd_chk(16'hFF72, 8'h11);
		rd_chk(16'hFF73, 8'h00);
		$display("test overrun done");
		mode(8'hED);
		u_asp_remote_uart.send(12'h133, 10);
		rd_chk(16'hFF73, 8'h02);
		rd_chk(16'hFF72, 8'h33);
		tx_chk(8'h81, 12'h281, 10);
		$display("test zero parity done");
		mode(8'hFD);
		u_asp_remote_uart.send(12'h201, 10);
		rd_chk(16'hFF73, 8'h04);
		rd_chk(16'hFF72, 8'h01);
		tx_chk(8'h03, 12'h203, 10);
		$display("test even parity done");
		mode(8'hF1);
		u_asp_remote_uart.send(12'h1D3, 9);
		rd_chk(16'hFF72, 8'h53);
		tx_chk(8'hD3, 12'h1D3, 9);
		$display("test seven bit done");
		wr(16'hFF72, 8'h00);
		repeat (20) @(negedge i_ref_clk);
		clk_supply = 1'b0;
		repeat (200) @(negedge i_ref_clk);
		check("frozen_pin", {11'h000, o_serial_out_pin}, 12'h000);
		clk_supply = 1'b1;
		wr(16'hFF70, 8'h01);
		mode(8'hF1);
		$display("test clock stop done");
		wr(16'hFF71, 8'h08);
		tx_chk(8'hD3, 12'h1D3, 9);
		$display("test timer base clock done");
		repeat (8) wr(16'hFF72, 8'h00);
		check("tx_ready", {11'h000, o_tx_ready}, 12'h001);
		wr(16'hFF72, 8'h00);
		check("tx_full", {11'h000, o_tx_ready}, 12'h000);
		$display("test transmit queue done");
		wr(16'hFF70, 8'h01);
		rd_chk(16'hFF72, 8'hFF);
		rd_chk(16'hFF70, 8'h01);
		check("out_pin", {11'h000, o_serial_out_pin}, 12'h001);
		check("tx_ready_off", {11'h000, o_tx_ready}, 12'h001);
		$display("test power off done");
		close_out();
	end
endmodule
